// ==== shared/lmdec_cfg.svh ====
// Purpose: Constants for the load and move instruction decoder
// Assumes: Included by bare name; definitions only
// Notes:   Opcodes, reg-field codes, clock counts and flag positions
`ifndef LMDEC_CFG_SVH
`define LMDEC_CFG_SVH

// ----------------------------------------------------------------------
// Opcode bytes
// ----------------------------------------------------------------------
`define LMDEC_OP_EA 8'h8d
`define LMDEC_OP_EXT_PTR 8'hc4
`define LMDEC_OP_FOURTH_PTR 8'hb4
`define LMDEC_OP_FIFTH_PTR 8'hb5
`define LMDEC_OP_STACK_PTR 8'hb2
`define LMDEC_OP_GRP_TBL 8'h01
`define LMDEC_OP_GRP_SEL 8'h00
`define LMDEC_OP_SEG_BOUND 8'h03
`define LMDEC_OP_FRAME_EXIT 8'hc9
`define LMDEC_OP_CNT_BR 8'he2
`define LMDEC_OP_CNT_BR_NZ 8'he0
`define LMDEC_OP_CNT_BR_Z 8'he1
`define LMDEC_OP_TO_SEG 8'h8e
`define LMDEC_OP_FROM_SEG 8'h8c
`define LMDEC_HI_IMM_REG 4'hb
`define LMDEC_HI_ACC 4'ha
`define LMDEC_LO_ACC_LOAD 3'h0
`define LMDEC_LO_ACC_STORE 3'h1

// ----------------------------------------------------------------------
// Reg-field sub-codes
// ----------------------------------------------------------------------
`define LMDEC_RF_GDT 3'h2
`define LMDEC_RF_IDT 3'h3
`define LMDEC_RF_MSW 3'h6
`define LMDEC_RF_LDT 3'h2
`define LMDEC_RF_TASK 3'h3
`define LMDEC_SEG_MAX 3'h5

// ----------------------------------------------------------------------
// Clock counts with all accesses hitting the level-one cache
// ----------------------------------------------------------------------
`define LMDEC_CYC_ONE 4'h1
`define LMDEC_CYC_PTR_REAL 4'h4
`define LMDEC_CYC_PTR_PROT 4'h9
`define LMDEC_CYC_SS_PROT 4'ha
`define LMDEC_CYC_DTBL 4'ha
`define LMDEC_CYC_LDT 4'h8
`define LMDEC_CYC_TASK 4'h9
`define LMDEC_CYC_MSW 4'hb
`define LMDEC_CYC_BOUND 4'h9
`define LMDEC_CYC_FRAME 4'h4
`define LMDEC_CYC_BRANCH 4'h2
`define LMDEC_CYC_SEG_PROT 4'h6

// ----------------------------------------------------------------------
// Flag write mask: OF DF IF TF SF ZF AF PF CF at bits 8..0
// ----------------------------------------------------------------------
`define LMDEC_FLAGS_NONE 9'h000
`define LMDEC_FLAG_ZERO 9'h008

`endif

// ==== shared/lmdec_pkg.sv ====
// Purpose: Types for the load and move instruction decoder
// Assumes: Used by scope, never imported
// Notes:   Class list covers only this decoder's instruction group
package lmdec_pkg;

    typedef enum logic [4:0] {
        LMDEC_NONE,
        LMDEC_EA_COMPUTE,
        LMDEC_EXT_PTR_PAIR,
        LMDEC_FOURTH_SEG_PTR,
        LMDEC_FIFTH_SEG_PTR,
        LMDEC_STACK_PTR_PAIR,
        LMDEC_GDT_LOAD,
        LMDEC_IDT_LOAD,
        LMDEC_LDT_LOAD,
        LMDEC_TASK_SEL_LOAD,
        LMDEC_MSW_LOAD,
        LMDEC_SEG_BOUND_LOAD,
        LMDEC_FRAME_EXIT,
        LMDEC_CNT_BRANCH,
        LMDEC_CNT_BRANCH_NZ,
        LMDEC_CNT_BRANCH_Z,
        LMDEC_TO_SEG_REG,
        LMDEC_FROM_SEG_REG,
        LMDEC_IMM_TO_REG,
        LMDEC_ACC_LOAD,
        LMDEC_ACC_STORE
    } lmdec_class_type;

    typedef struct packed {
        lmdec_class_type cls;
        logic [3:0] cycles;
        logic [8:0] flag_wr;
        logic illegal;
        logic wide;
        logic [2:0] reg_sel;
    } lmdec_dec_type;

endpackage : lmdec_pkg

// ==== logic/lmdec_core.sv ====
// Purpose: Decode and sequence the load and move instruction group
// Assumes: Opcode bytes arrive synchronous to clk, one instruction
//          per accepted request; mem_hit says fetch and operands hit
// Notes:   Notes on behaviour below; counts are cache-hit figures
//
// Notes on behaviour
// - 8D with mod-reg-r/m computes an address, flags kept, 1 clock
// - C4 loads far pointer into register and extra segment, 4/9
// - 0F B4 loads far pointer with fourth data segment, 4/9 clocks
// - 0F B5 loads far pointer with fifth data segment, 4/9 clocks
// - 0F B2 loads far pointer with stack segment, 4/10 clocks
// - 0F 01 reg 010 loads global descriptor table, 10 clocks
// - 0F 01 reg 011 loads interrupt descriptor table, 10 clocks
// - 0F 00 reg 010 loads local table selector, 8 protected only
// - 0F 00 reg 011 loads task selector, 9 clocks protected only
// - 0F 01 reg 110 loads machine status word, 11 clocks
// - 0F 03 loads segment bound, only zero flag changes, 9 clocks
// - C9 tears down stack frame, flags kept, 4 clocks
// - E2, E0, E1 counted branches with 8-bit offset, 2 clocks
// - 8E moves operand to segment register, 1 real, 6 protected
// - 8C copies segment register out, 1 clock, flags kept
// - B with width bit and register takes immediate, 1 clock
// - A 000w loads, A 001w stores accumulator directly, 1 clock
`timescale 1ns/10ps
`include "lmdec_cfg.svh"

module lmdec_core #(
    parameter int CNT_W = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_two_byte,
    input wire logic [7:0] in_opcode,
    input wire logic [7:0] in_modrm,
    input wire logic in_prot_mode,
    input wire logic mem_hit,
    output lmdec_pkg::lmdec_class_type dec_class,
    output logic [CNT_W-1:0] dec_cycles,
    output logic [8:0] dec_flag_wr,
    output logic dec_illegal,
    output logic dec_wide,
    output logic [2:0] dec_reg,
    output logic busy,
    output logic done
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic lmdec_pkg::lmdec_dec_type decode(
        input logic two_byte,
        input logic [7:0] op,
        input logic [7:0] modrm,
        input logic prot
    );
        lmdec_pkg::lmdec_dec_type d;
        logic [3:0] ptr_cyc;
        d.cls = lmdec_pkg::LMDEC_NONE;
        d.cycles = `LMDEC_CYC_ONE;
        d.flag_wr = `LMDEC_FLAGS_NONE;
        d.illegal = 1'b0;
        d.wide = op[0];
        d.reg_sel = modrm[5:3];
        ptr_cyc = prot ? `LMDEC_CYC_PTR_PROT : `LMDEC_CYC_PTR_REAL;
        if (two_byte) begin
            case (op)
                `LMDEC_OP_FOURTH_PTR: begin
                    d.cls = lmdec_pkg::LMDEC_FOURTH_SEG_PTR;
                    d.cycles = ptr_cyc;
                end
                `LMDEC_OP_FIFTH_PTR: begin
                    d.cls = lmdec_pkg::LMDEC_FIFTH_SEG_PTR;
                    d.cycles = ptr_cyc;
                end
                `LMDEC_OP_STACK_PTR: begin
                    d.cls = lmdec_pkg::LMDEC_STACK_PTR_PAIR;
                    d.cycles = prot ? `LMDEC_CYC_SS_PROT
                                    : `LMDEC_CYC_PTR_REAL;
                end
                `LMDEC_OP_GRP_TBL: begin
                    case (modrm[5:3])
                        `LMDEC_RF_GDT: begin
                            d.cls = lmdec_pkg::LMDEC_GDT_LOAD;
                            d.cycles = `LMDEC_CYC_DTBL;
                        end
                        `LMDEC_RF_IDT: begin
                            d.cls = lmdec_pkg::LMDEC_IDT_LOAD;
                            d.cycles = `LMDEC_CYC_DTBL;
                        end
                        `LMDEC_RF_MSW: begin
                            d.cls = lmdec_pkg::LMDEC_MSW_LOAD;
                            d.cycles = `LMDEC_CYC_MSW;
                        end
                        default: begin
                        end
                    endcase
                end
                `LMDEC_OP_GRP_SEL: begin
                    // No real-mode form: refused as illegal there
                    case (modrm[5:3])
                        `LMDEC_RF_LDT: begin
                            d.cls = lmdec_pkg::LMDEC_LDT_LOAD;
                            d.cycles = `LMDEC_CYC_LDT;
                            d.illegal = !prot;
                        end
                        `LMDEC_RF_TASK: begin
                            d.cls = lmdec_pkg::LMDEC_TASK_SEL_LOAD;
                            d.cycles = `LMDEC_CYC_TASK;
                            d.illegal = !prot;
                        end
                        default: begin
                        end
                    endcase
                end
                `LMDEC_OP_SEG_BOUND: begin
                    d.cls = lmdec_pkg::LMDEC_SEG_BOUND_LOAD;
                    d.cycles = `LMDEC_CYC_BOUND;
                    d.flag_wr = `LMDEC_FLAG_ZERO;
                    d.illegal = !prot;
                end
                default: begin
                end
            endcase
        end else begin
            case (op)
                `LMDEC_OP_EA: begin
                    d.cls = lmdec_pkg::LMDEC_EA_COMPUTE;
                end
                `LMDEC_OP_EXT_PTR: begin
                    d.cls = lmdec_pkg::LMDEC_EXT_PTR_PAIR;
                    d.cycles = ptr_cyc;
                end
                `LMDEC_OP_FRAME_EXIT: begin
                    d.cls = lmdec_pkg::LMDEC_FRAME_EXIT;
                    d.cycles = `LMDEC_CYC_FRAME;
                end
                `LMDEC_OP_CNT_BR: begin
                    d.cls = lmdec_pkg::LMDEC_CNT_BRANCH;
                    d.cycles = `LMDEC_CYC_BRANCH;
                end
                `LMDEC_OP_CNT_BR_NZ: begin
                    d.cls = lmdec_pkg::LMDEC_CNT_BRANCH_NZ;
                    d.cycles = `LMDEC_CYC_BRANCH;
                end
                `LMDEC_OP_CNT_BR_Z: begin
                    d.cls = lmdec_pkg::LMDEC_CNT_BRANCH_Z;
                    d.cycles = `LMDEC_CYC_BRANCH;
                end
                `LMDEC_OP_TO_SEG: begin
                    d.cls = lmdec_pkg::LMDEC_TO_SEG_REG;
                    d.cycles = prot ? `LMDEC_CYC_SEG_PROT
                                    : `LMDEC_CYC_ONE;
                    d.illegal = modrm[5:3] > `LMDEC_SEG_MAX;
                end
                `LMDEC_OP_FROM_SEG: begin
                    d.cls = lmdec_pkg::LMDEC_FROM_SEG_REG;
                    d.illegal = modrm[5:3] > `LMDEC_SEG_MAX;
                end
                default: begin
                    if (op[7:4] == `LMDEC_HI_IMM_REG) begin
                        d.cls = lmdec_pkg::LMDEC_IMM_TO_REG;
                        d.wide = op[3];
                        d.reg_sel = op[2:0];
                    end else if (op[7:4] == `LMDEC_HI_ACC
                                 && op[3:1] == `LMDEC_LO_ACC_LOAD) begin
                        d.cls = lmdec_pkg::LMDEC_ACC_LOAD;
                    end else if (op[7:4] == `LMDEC_HI_ACC
                                 && op[3:1] == `LMDEC_LO_ACC_STORE) begin
                        d.cls = lmdec_pkg::LMDEC_ACC_STORE;
                    end
                end
            endcase
        end
        if (d.cls == lmdec_pkg::LMDEC_NONE) begin
            d.illegal = 1'b1;
        end
        return d;
    endfunction : decode

    // ------------------------------------------------------------------
    // Handshake and sequencing
    // ------------------------------------------------------------------
    lmdec_pkg::lmdec_dec_type dec_next;
    logic accept;
    logic busy_reg;
    logic [CNT_W-1:0] cnt_reg;

    assign dec_next = decode(in_two_byte, in_opcode, in_modrm,
                             in_prot_mode);
    // A miss holds whichever count cycle it falls in until the access hits
    assign done = busy_reg && cnt_reg == CNT_W'(1) && mem_hit;
    assign in_ready = !busy_reg || done;
    assign accept = in_valid && in_ready;
    assign busy = busy_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else if (accept) begin
            busy_reg <= 1'b1;
        end else if (done) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (accept) begin
            cnt_reg <= CNT_W'(dec_next.cycles);
        end else if (busy_reg && mem_hit && cnt_reg != CNT_W'(1)) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
        end
    end

    // Decoded fields are held for the whole instruction
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dec_class <= lmdec_pkg::LMDEC_NONE;
            dec_cycles <= '0;
            dec_flag_wr <= `LMDEC_FLAGS_NONE;
            dec_illegal <= 1'b0;
            dec_wide <= 1'b0;
            dec_reg <= 3'h0;
        end else if (accept) begin
            dec_class <= dec_next.cls;
            dec_cycles <= CNT_W'(dec_next.cycles);
            dec_flag_wr <= dec_next.flag_wr;
            dec_illegal <= dec_next.illegal;
            dec_wide <= dec_next.wide;
            dec_reg <= dec_next.reg_sel;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic acc1;
    assign acc1 = accept && !in_two_byte;

    chk_ea_one_clk: assert property (
        acc1 && in_opcode == `LMDEC_OP_EA ##1 mem_hit |-> done
            && dec_flag_wr == `LMDEC_FLAGS_NONE)
        else $error("address compute not done in one clock");
    chk_ext_ptr_cnt: assert property (
        acc1 && in_opcode == `LMDEC_OP_EXT_PTR |=> cnt_reg ==
            ($past(in_prot_mode) ? `LMDEC_CYC_PTR_PROT : `LMDEC_CYC_PTR_REAL))
        else $error("extra segment pointer count wrong");
    chk_fourth_ptr_cnt: assert property (
        accept && in_two_byte && in_opcode == `LMDEC_OP_FOURTH_PTR
            && in_prot_mode |=> cnt_reg == `LMDEC_CYC_PTR_PROT)
        else $error("fourth segment pointer count wrong");
    chk_fifth_ptr_cnt: assert property (
        accept && in_two_byte && in_opcode == `LMDEC_OP_FIFTH_PTR
            && !in_prot_mode |=> cnt_reg == `LMDEC_CYC_PTR_REAL)
        else $error("fifth segment pointer count wrong");
    chk_stack_ptr_cnt: assert property (
        accept && in_two_byte && in_opcode == `LMDEC_OP_STACK_PTR
            && in_prot_mode |=> cnt_reg == `LMDEC_CYC_SS_PROT)
        else $error("stack pointer load count wrong");
    chk_dtbl_cnt: assert property (
        accept && in_two_byte && in_opcode == `LMDEC_OP_GRP_TBL
            && in_modrm[5:3] == `LMDEC_RF_GDT
        |=> dec_class == lmdec_pkg::LMDEC_GDT_LOAD
            && cnt_reg == `LMDEC_CYC_DTBL)
        else $error("global table load decode wrong");
    chk_itbl_cnt: assert property (
        accept && in_two_byte && in_opcode == `LMDEC_OP_GRP_TBL
            && in_modrm[5:3] == `LMDEC_RF_IDT
        |=> dec_class == lmdec_pkg::LMDEC_IDT_LOAD
            && cnt_reg == `LMDEC_CYC_DTBL)
        else $error("interrupt table load decode wrong");
    chk_ldt_real_ill: assert property (
        accept && dec_next.cls == lmdec_pkg::LMDEC_LDT_LOAD
        |=> dec_illegal == !$past(in_prot_mode)
            && cnt_reg == `LMDEC_CYC_LDT)
        else $error("local table load mode check wrong");
    chk_task_cnt: assert property (
        accept && dec_next.cls == lmdec_pkg::LMDEC_TASK_SEL_LOAD
        |=> cnt_reg == `LMDEC_CYC_TASK)
        else $error("task selector load count wrong");
    chk_task_real_ill: assert property (
        accept && dec_next.cls == lmdec_pkg::LMDEC_TASK_SEL_LOAD
        |=> dec_illegal == !$past(in_prot_mode))
        else $error("task selector load mode check wrong");
    chk_msw_cnt: assert property (
        accept && dec_next.cls == lmdec_pkg::LMDEC_MSW_LOAD
        |=> cnt_reg == `LMDEC_CYC_MSW)
        else $error("status word load count wrong");
    chk_bound_zf_only: assert property (
        busy_reg && dec_flag_wr != `LMDEC_FLAGS_NONE
        |-> dec_flag_wr == `LMDEC_FLAG_ZERO
            && dec_class == lmdec_pkg::LMDEC_SEG_BOUND_LOAD)
        else $error("flag write outside segment bound load");
    chk_frame_four: assert property (
        acc1 && in_opcode == `LMDEC_OP_FRAME_EXIT ##1 mem_hit [*4]
        |-> done)
        else $error("frame exit not done in four hit clocks");
    chk_branch_two: assert property (
        acc1 && in_opcode[7:2] == `LMDEC_OP_CNT_BR_NZ >> 2
            && in_opcode[1:0] != 2'h3 ##1 mem_hit ##1 mem_hit
        |-> done && !$past(done))
        else $error("counted branch not two clocks");
    chk_to_seg_cnt: assert property (
        acc1 && in_opcode == `LMDEC_OP_TO_SEG |=> cnt_reg ==
            ($past(in_prot_mode) ? `LMDEC_CYC_SEG_PROT : `LMDEC_CYC_ONE))
        else $error("move to segment count wrong");
    chk_from_seg_cnt: assert property (
        acc1 && in_opcode == `LMDEC_OP_FROM_SEG |=> cnt_reg ==
            `LMDEC_CYC_ONE)
        else $error("move from segment count wrong");
    chk_imm_reg_field: assert property (
        acc1 && in_opcode[7:4] == `LMDEC_HI_IMM_REG
        |=> dec_reg == $past(in_opcode[2:0])
            && dec_wide == $past(in_opcode[3])
            && cnt_reg == `LMDEC_CYC_ONE)
        else $error("short immediate move fields wrong");
    chk_acc_store: assert property (
        acc1 && in_opcode[7:1] == {`LMDEC_HI_ACC, `LMDEC_LO_ACC_STORE}
        |=> dec_class == lmdec_pkg::LMDEC_ACC_STORE
            && cnt_reg == `LMDEC_CYC_ONE)
        else $error("accumulator store decode wrong");
    chk_acc_load: assert property (
        acc1 && in_opcode[7:1] == {`LMDEC_HI_ACC, `LMDEC_LO_ACC_LOAD}
        |=> dec_class == lmdec_pkg::LMDEC_ACC_LOAD
            && cnt_reg == `LMDEC_CYC_ONE)
        else $error("accumulator load decode wrong");
    chk_busy_clears: assert property (
        done && !accept |=> !busy_reg)
        else $error("busy held after last clock");
    chk_miss_stall: assert property (
        busy_reg && !mem_hit |=> busy_reg && $stable(cnt_reg))
        else $error("count moved during a cache miss");

    cov_back_to_back: cover property (done && accept);
    cov_miss_stall: cover property ((busy_reg && !mem_hit) [*2] ##1 done);
    cov_bound_load: cover property (
        busy_reg && dec_class == lmdec_pkg::LMDEC_SEG_BOUND_LOAD);
    cov_illegal: cover property (busy_reg && dec_illegal);

endmodule : lmdec_core

// ==== verif/lmdec_tb.sv ====
// Purpose: Self-checking bench for the load and move instruction decoder
// Assumes: Default counter width; accesses hit unless a test stalls them
// Notes:   One request at a time; each test waits for done under a bound
`timescale 1ns/10ps

module tb;

    // ------------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------------
    logic clk;
    logic rst_b;
    logic in_valid;
    logic in_ready;
    logic in_two_byte;
    logic [7:0] in_opcode;
    logic [7:0] in_modrm;
    logic in_prot_mode;
    logic mem_hit;
    lmdec_pkg::lmdec_class_type dec_class;
    logic [3:0] dec_cycles;
    logic [8:0] dec_flag_wr;
    logic dec_illegal;
    logic dec_wide;
    logic [2:0] dec_reg;
    logic busy;
    logic done;
    int n_mismatch;
    int checks_done;

    lmdec_core #(.CNT_W(4)) lmdec_core_inst (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_two_byte(in_two_byte),
        .in_opcode(in_opcode),
        .in_modrm(in_modrm),
        .in_prot_mode(in_prot_mode),
        .mem_hit(mem_hit),
        .dec_class(dec_class),
        .dec_cycles(dec_cycles),
        .dec_flag_wr(dec_flag_wr),
        .dec_illegal(dec_illegal),
        .dec_wide(dec_wide),
        .dec_reg(dec_reg),
        .busy(busy),
        .done(done)
    );

    always #2 clk = ~clk;

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic fail(input string msg);
        n_mismatch++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask : fail

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic check_reset_state;
        checks_done += 3;
        if (busy !== 1'b0 || done !== 1'b0) fail("busy or done in reset");
        if (in_ready !== 1'b1) fail("ready low in reset");
        if (dec_class !== lmdec_pkg::LMDEC_NONE) fail("class not cleared");
    endtask : check_reset_state

    // A zero count with ill set means the count is left open
    task automatic run_op(input logic tb2, input logic [7:0] op,
                          input logic [7:0] mr, input logic prot,
                          input logic [3:0] cyc,
                          input lmdec_pkg::lmdec_class_type cls,
                          input logic [8:0] flg = 9'h000,
                          input logic ill = 1'b0, input int miss = 0);
        int n;
        logic bform;
        logic [3:0] exp_wr;
        bform = !tb2 && op[7:4] == 4'hb;
        exp_wr = bform ? {op[3], op[2:0]} : {op[0], mr[5:3]};
        @(posedge clk);
        in_valid <= 1'b1;
        in_two_byte <= tb2;
        in_opcode <= op;
        in_modrm <= mr;
        in_prot_mode <= prot;
        @(negedge clk);
        for (n = 0; n < 50 && in_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        in_valid <= 1'b0;
        mem_hit <= (miss == 0);
        for (n = 1; n < 40; n++) begin
            @(negedge clk);
            if (n == 1) begin
                checks_done += 7;
                if (busy !== 1'b1) fail("busy not raised");
                if (in_ready !== done) fail("ready while busy");
                if ((cyc != 0 || !ill) && dec_cycles !== cyc) begin
                    fail("cycle count field");
                end
                if (dec_illegal !== ill) fail("illegal flag");
                if (!ill && dec_class !== cls) fail("instruction class");
                if (!ill && dec_flag_wr !== flg) fail("flag write mask");
                if (!ill && {dec_wide, dec_reg} !== exp_wr) fail("fields");
            end
            if (done === 1'b1) break;
            if (n == miss) begin
                @(posedge clk);
                mem_hit <= 1'b1;
            end
        end
        checks_done += 2;
        if ((cyc != 0 || !ill) && n != cyc + miss) begin
            fail("clock count");
        end
        @(negedge clk);
        if (busy !== 1'b0) fail("busy held past done");
    endtask : run_op

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_ea;
        run_op(1'b0, 8'h8d, 8'h04, 1'b0, 4'h1,
               lmdec_pkg::LMDEC_EA_COMPUTE);
        run_op(1'b0, 8'h8d, 8'hfb, 1'b1, 4'h1,
               lmdec_pkg::LMDEC_EA_COMPUTE);
        $display("test ea done");
    endtask : t_ea

    task automatic t_far_ptr;
        logic [7:0] ops [4] = '{8'hc4, 8'hb4, 8'hb5, 8'hb2};
        lmdec_pkg::lmdec_class_type cl [4] = '{
            lmdec_pkg::LMDEC_EXT_PTR_PAIR, lmdec_pkg::LMDEC_FOURTH_SEG_PTR,
            lmdec_pkg::LMDEC_FIFTH_SEG_PTR, lmdec_pkg::LMDEC_STACK_PTR_PAIR};
        logic [3:0] cyc;
        for (int i = 0; i < 4; i++) begin
            for (int p = 0; p < 2; p++) begin
                cyc = (p == 0) ? 4'h4 : ((i == 3) ? 4'ha : 4'h9);
                run_op(i != 0, ops[i], 8'h29,
                       p[0], cyc, cl[i]);
            end
        end
        $display("test far pointer done");
    endtask : t_far_ptr

    task automatic t_tables;
        for (int p = 0; p < 2; p++) begin
            run_op(1'b1, 8'h01, 8'h10, p[0], 4'ha,
                   lmdec_pkg::LMDEC_GDT_LOAD);
            run_op(1'b1, 8'h01, 8'h1e, p[0], 4'ha,
                   lmdec_pkg::LMDEC_IDT_LOAD);
            run_op(1'b1, 8'h01, 8'hf0, p[0], 4'hb,
                   lmdec_pkg::LMDEC_MSW_LOAD);
        end
        run_op(1'b1, 8'h01, 8'h00, 1'b1, 4'h0, lmdec_pkg::LMDEC_NONE,
               9'h000, 1'b1);
        run_op(1'b0, 8'h90, 8'h00, 1'b0, 4'h1, lmdec_pkg::LMDEC_NONE,
               9'h000, 1'b1);
        $display("test tables done");
    endtask : t_tables

    task automatic t_selectors;
        run_op(1'b1, 8'h00, 8'hd0, 1'b1, 4'h8,
               lmdec_pkg::LMDEC_LDT_LOAD);
        run_op(1'b1, 8'h00, 8'h18, 1'b1, 4'h9,
               lmdec_pkg::LMDEC_TASK_SEL_LOAD);
        run_op(1'b1, 8'h03, 8'hc1, 1'b1, 4'h9,
               lmdec_pkg::LMDEC_SEG_BOUND_LOAD, 9'h008);
        // Protected-only loads keep their count in real mode and must be refused
        run_op(1'b1, 8'h00, 8'hd0, 1'b0, 4'h8, lmdec_pkg::LMDEC_NONE,
               9'h000, 1'b1);
        run_op(1'b1, 8'h00, 8'h18, 1'b0, 4'h9, lmdec_pkg::LMDEC_NONE,
               9'h000, 1'b1);
        run_op(1'b1, 8'h03, 8'hc1, 1'b0, 4'h9, lmdec_pkg::LMDEC_NONE,
               9'h000, 1'b1);
        $display("test selectors done");
    endtask : t_selectors

    task automatic t_frame_branch;
        run_op(1'b0, 8'hc9, 8'h00, 1'b0, 4'h4,
               lmdec_pkg::LMDEC_FRAME_EXIT);
        run_op(1'b0, 8'hc9, 8'h00, 1'b1, 4'h4,
               lmdec_pkg::LMDEC_FRAME_EXIT);
        run_op(1'b0, 8'he2, 8'h00, 1'b0, 4'h2,
               lmdec_pkg::LMDEC_CNT_BRANCH);
        run_op(1'b0, 8'he0, 8'h00, 1'b1, 4'h2,
               lmdec_pkg::LMDEC_CNT_BRANCH_NZ);
        run_op(1'b0, 8'he1, 8'h00, 1'b0, 4'h2,
               lmdec_pkg::LMDEC_CNT_BRANCH_Z);
        $display("test frame and branch done");
    endtask : t_frame_branch

    task automatic t_seg_moves;
        run_op(1'b0, 8'h8e, 8'h18, 1'b0, 4'h1,
               lmdec_pkg::LMDEC_TO_SEG_REG);
        run_op(1'b0, 8'h8e, 8'he8, 1'b1, 4'h6,
               lmdec_pkg::LMDEC_TO_SEG_REG);
        run_op(1'b0, 8'h8c, 8'h20, 1'b0, 4'h1,
               lmdec_pkg::LMDEC_FROM_SEG_REG);
        run_op(1'b0, 8'h8c, 8'h00, 1'b1, 4'h1,
               lmdec_pkg::LMDEC_FROM_SEG_REG);
        run_op(1'b0, 8'h8e, 8'hf0, 1'b1, 4'h0, lmdec_pkg::LMDEC_NONE,
               9'h000, 1'b1);
        $display("test segment moves done");
    endtask : t_seg_moves

    task automatic t_short_moves;
        for (int i = 0; i < 16; i++) begin
            run_op(1'b0, {4'hb, i[3:0]}, 8'h00, i[0], 4'h1,
                   lmdec_pkg::LMDEC_IMM_TO_REG);
        end
        for (int i = 0; i < 4; i++) begin
            run_op(1'b0, {6'h28, i[1:0]}, 8'h00, 1'b0, 4'h1,
                   (i < 2) ? lmdec_pkg::LMDEC_ACC_LOAD
                           : lmdec_pkg::LMDEC_ACC_STORE);
        end
        $display("test short moves done");
    endtask : t_short_moves

    // A missed access must stretch the count, never shorten it
    task automatic t_miss;
        run_op(1'b0, 8'hc9, 8'h00, 1'b0, 4'h4,
               lmdec_pkg::LMDEC_FRAME_EXIT, 9'h000, 1'b0, 3);
        run_op(1'b0, 8'h8d, 8'h00, 1'b1, 4'h1,
               lmdec_pkg::LMDEC_EA_COMPUTE, 9'h000, 1'b0, 2);
        $display("test cache miss done");
    endtask : t_miss

    task automatic t_mid_reset;
        @(posedge clk);
        in_valid <= 1'b1;
        in_two_byte <= 1'b1;
        in_opcode <= 8'h01;
        in_modrm <= 8'h30;
        @(posedge clk);
        in_valid <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b0;
        @(negedge clk);
        check_reset_state();
        @(posedge clk);
        rst_b <= 1'b1;
        run_op(1'b0, 8'h8d, 8'h00, 1'b0, 4'h1,
               lmdec_pkg::LMDEC_EA_COMPUTE);
        $display("test reset in flight done");
    endtask : t_mid_reset

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        in_valid = 1'b0;
        in_two_byte = 1'b0;
        in_opcode = 8'h00;
        in_modrm = 8'h00;
        in_prot_mode = 1'b0;
        mem_hit = 1'b1;
        n_mismatch = 0;
        checks_done = 0;
        @(negedge clk);
        check_reset_state();
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_ea();
        t_far_ptr();
        t_tables();
        t_selectors();
        t_frame_branch();
        t_seg_moves();
        t_short_moves();
        t_miss();
        t_mid_reset();
        complete_run();
    end

    // Tests need well under 2000 cycles; this bound only catches a hang
    initial begin
        #40000;
        fail("watchdog expired");
        complete_run();
    end

endmodule : tb
